// File: dmsc_device.sv
/*
 dmsc_device: device end of the dual mode serial control port: mode detect,
 I2C/SPI slave, address match, register pointer, chain enable output.
 assumes: all link pins are asynchronous; scl, sda, cs_n and mosi are synchronised here; the reset pin
 is the chain reset and is also combined with rst_n.
*/
// Implementation choice: a plain address, write data and write strobe port to the registers.
//
// What this block does
// - chain enable low while held in reset
// - chain enable high after reset and enable bit
// - controller addresses chain devices one by one
// - one write sets address and enable together
// - at most 128 chained devices per bus
// - chip select falling edge selects SPI mode
// - address pin sampled as default address lsb
// - start and stop only while clock high
// - respond only to matching address; the individual one needs no enable
// - foreign-address read ignored until stop, start
// - byte after address is register pointer
// - read returns the pointed register
// - pointer msb enables auto-increment after writes
// - acknowledge each received byte
// - controller sets pointer by aborted write
// - SPI data sampled on clock rising edge
// - SPI default address is 1000000b
// - SPI frame: address, rw, pointer, data
// - SPI read request ignored until reselect
// - address registers at 1Bh, 1Ah, 19h
// - group address only when its enable set
// - group addresses never answer reads
`timescale 1ns/100ps
module dmsc_device (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic address_select_pin,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_write,
   input wire logic [7:0] reg_rdata,
   dmsc_link_if.device link
);
   typedef enum logic [1:0] {D_IDLE, D_ADDR, D_PTR, D_DATA} dst_t;
   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic [2:0] cs_s;
      logic [1:0] mosi_s;
      logic [1:0] rst_s;
      logic [1:0] strap_s;
      logic strapped;
      dmsc_pkg::dmsc_mode_t mode;
      dst_t st;
      logic [2:0] bitn;
      logic [7:0] sh;
      logic ack;
      logic tx;
      logic ignore;
      logic rd;
      logic inc;
      logic [6:0] ptr;
      logic [7:0] indiv;
      logic [7:0] grp1;
      logic [7:0] grp2;
      logic [7:0] out;
      logic oe;
      logic wstb;
      logic [7:0] wdat;
      logic [7:0] wadr;
   } dmsc_dst_t;
   dmsc_dst_t r, next_r;
   logic arst_n;
   logic scl_rise, scl_fall, sda_h, start_c, stop_c, cs_fall, cs_rise, sbit;
   logic [7:0] wbyte;
   logic amatch_w, amatch_r;
   assign arst_n = rst_n && link.reset_n;
   // first stages feed only the second stages; edges use stages 2 and 3
   assign scl_rise = r.scl_s[1] && !r.scl_s[2];
   assign scl_fall = !r.scl_s[1] && r.scl_s[2];
   assign sda_h = r.sda_s[1];
   assign start_c = r.scl_s[1] && !r.sda_s[1] && r.sda_s[2];
   assign stop_c = r.scl_s[1] && r.sda_s[1] && !r.sda_s[2];
   assign cs_fall = !r.cs_s[1] && r.cs_s[2];
   assign cs_rise = r.cs_s[1] && !r.cs_s[2];
   assign sbit = (r.mode == dmsc_pkg::DMSC_MODE_SPI) ? r.mosi_s[1] : sda_h;
   assign wbyte = {r.sh[6:0], sbit};
   assign amatch_r = wbyte[7:1] == r.indiv[7:1];
   assign amatch_w = wbyte[7:1] == r.indiv[7:1]
      || (r.grp1[dmsc_pkg::ENABLE_BIT] && wbyte[7:1] == r.grp1[7:1])
      || (r.grp2[dmsc_pkg::ENABLE_BIT] && wbyte[7:1] == r.grp2[7:1]);
   assign link.chain_enable_out = r.indiv[dmsc_pkg::ENABLE_BIT] && r.strapped;
   assign link.sda_dev_oe = r.oe;
   assign reg_write = r.wstb;
   assign reg_wdata = r.wdat;
   assign reg_addr = r.wadr;
   function automatic logic [7:0] rd_reg(input logic [6:0] a, input dmsc_dst_t s,
                                         input logic [7:0] ext);
      rd_reg = ext;
      if ({1'b0, a} == dmsc_pkg::REG_INDIV) rd_reg = s.indiv;
      if ({1'b0, a} == dmsc_pkg::REG_GROUP1) rd_reg = s.grp1;
      if ({1'b0, a} == dmsc_pkg::REG_GROUP2) rd_reg = s.grp2;
   endfunction
   always_comb begin
      next_r = r;
      next_r.scl_s = {r.scl_s[1:0], link.scl};
      next_r.sda_s = {r.sda_s[1:0], link.sda};
      next_r.cs_s = {r.cs_s[1:0], link.cs_n};
      next_r.mosi_s = {r.mosi_s[0], link.mosi};
      next_r.rst_s = {r.rst_s[0], 1'b1};
      next_r.strap_s = {r.strap_s[0], address_select_pin};
      // between writes the port shows the pointer, so reads see its register
      next_r.wadr = {1'b0, r.ptr};
      next_r.wstb = 1'b0;
      if (!r.strapped && r.rst_s[1]) begin
         // strap taken once, just after reset release
         next_r.strapped = 1'b1;
         next_r.mode = dmsc_pkg::DMSC_MODE_I2C;
         next_r.indiv = {dmsc_pkg::I2C_DEFAULT_BASE[6:1], r.strap_s[1], 1'b0};
         next_r.grp1 = next_r.indiv;
         next_r.grp2 = next_r.indiv;
      end
      if (r.strapped && r.mode != dmsc_pkg::DMSC_MODE_SPI && cs_fall) begin
         next_r.mode = dmsc_pkg::DMSC_MODE_SPI;
         next_r.indiv = {dmsc_pkg::SPI_DEFAULT_ADDR, 1'b0};
         next_r.grp1 = next_r.indiv;
         next_r.grp2 = next_r.indiv;
         next_r.oe = 1'b0;
      end
      if (next_r.mode == dmsc_pkg::DMSC_MODE_SPI) begin
         if (cs_fall) begin
            next_r.st = D_ADDR;
            next_r.bitn = 3'h0;
            next_r.ignore = 1'b0;
         end else if (cs_rise || r.cs_s[1]) begin
            next_r.st = D_IDLE;
         end else if (scl_rise && r.st != D_IDLE && !r.ignore) begin
            next_r.sh = wbyte;
            next_r.bitn = r.bitn + 3'h1;
            if (r.bitn == dmsc_pkg::BIT_LAST) begin
               unique case (r.st)
                  D_ADDR: begin
                     if (wbyte[0] || !amatch_w) next_r.ignore = 1'b1;
                     next_r.st = D_PTR;
                  end
                  D_PTR: begin
                     next_r.ptr = wbyte[dmsc_pkg::MAP_BITS-1:0];
                     next_r.inc = wbyte[dmsc_pkg::POINTER_AUTO_INCREMENT_BIT];
                     next_r.st = D_DATA;
                  end
                  default: begin
                     next_r.wstb = 1'b1;
                     next_r.wdat = wbyte;
                     next_r.wadr = {1'b0, r.ptr};
                     if ({1'b0, r.ptr} == dmsc_pkg::REG_INDIV) next_r.indiv = wbyte;
                     if ({1'b0, r.ptr} == dmsc_pkg::REG_GROUP1) next_r.grp1 = wbyte;
                     if ({1'b0, r.ptr} == dmsc_pkg::REG_GROUP2) next_r.grp2 = wbyte;
                     if (r.inc) next_r.ptr = r.ptr + 7'h1;
                  end
               endcase
            end
         end
      end else if (r.mode == dmsc_pkg::DMSC_MODE_I2C) begin
         if (stop_c) begin
            next_r.st = D_IDLE;
            next_r.ignore = 1'b0;
            next_r.oe = 1'b0;
         end else if (start_c && !r.ignore) begin
            next_r.st = D_ADDR;
            next_r.bitn = 3'h0;
            next_r.ack = 1'b0;
            next_r.tx = 1'b0;
            next_r.oe = 1'b0;
         end else if (r.st != D_IDLE && scl_fall) begin
            // drive on falling edge: ack slot, read data bits, or release
            if (r.ack) begin
               next_r.oe = !r.tx || r.st == D_ADDR;
            end else if (r.tx) begin
               next_r.oe = !r.out[7];
            end else begin
               next_r.oe = 1'b0;
            end
         end else if (r.st != D_IDLE && scl_rise) begin
            if (r.ack) begin
               next_r.ack = 1'b0;
               if (r.tx) begin
                  // own ack of a read address, else the controller's answer to our byte
                  if (r.st == D_ADDR) next_r.st = D_DATA;
                  else if (sda_h) next_r.st = D_IDLE;
                  next_r.out = rd_reg(r.ptr, r, reg_rdata);
               end
            end else if (r.tx) begin
               next_r.out = {r.out[6:0], 1'b0};
               next_r.bitn = r.bitn + 3'h1;
               if (r.bitn == dmsc_pkg::BIT_LAST) next_r.ack = 1'b1;
            end else begin
               next_r.sh = wbyte;
               next_r.bitn = r.bitn + 3'h1;
               if (r.bitn == dmsc_pkg::BIT_LAST) begin
                  next_r.ack = 1'b1;
                  unique case (r.st)
                     D_ADDR: begin
                        if (wbyte[0] && amatch_r) begin
                           next_r.tx = 1'b1;
                           next_r.out = rd_reg(r.ptr, r, reg_rdata);
                        end else if (wbyte[0]) begin
                           next_r.ignore = 1'b1;
                           next_r.st = D_IDLE;
                           next_r.ack = 1'b0;
                        end else if (amatch_w) begin
                           next_r.st = D_PTR;
                        end else begin
                           next_r.st = D_IDLE;
                           next_r.ack = 1'b0;
                        end
                     end
                     D_PTR: begin
                        next_r.ptr = wbyte[dmsc_pkg::MAP_BITS-1:0];
                        next_r.inc = wbyte[dmsc_pkg::POINTER_AUTO_INCREMENT_BIT];
                        next_r.st = D_DATA;
                     end
                     default: begin
                        next_r.wstb = 1'b1;
                        next_r.wdat = wbyte;
                        next_r.wadr = {1'b0, r.ptr};
                        if ({1'b0, r.ptr} == dmsc_pkg::REG_INDIV) next_r.indiv = wbyte;
                        if ({1'b0, r.ptr} == dmsc_pkg::REG_GROUP1) next_r.grp1 = wbyte;
                        if ({1'b0, r.ptr} == dmsc_pkg::REG_GROUP2) next_r.grp2 = wbyte;
                        if (r.inc) next_r.ptr = r.ptr + 7'h1;
                     end
                  endcase
               end
            end
         end
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
         r.scl_s <= 3'h7;
         r.sda_s <= 3'h7;
         r.cs_s <= 3'h7;
      end else begin
         r <= next_r;
      end
   end
endmodule // dmsc_device

// File: dmsc_pkg.sv
/*
 dmsc_pkg: shared constants and types for the dual mode serial control port
 (device end) and its controller end.
 assumes: both ends run on one 20 MHz clock; nothing is imported.
*/
package dmsc_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int SCL_NS = 5000;
   localparam int HALF_BIT_CYCLES = (SCL_NS / 2) * (CLK_HZ / 1000000) / 1000;
   localparam logic [7:0] REG_GROUP2 = 8'h19;
   localparam logic [7:0] REG_GROUP1 = 8'h1A;
   localparam logic [7:0] REG_INDIV = 8'h1B;
   localparam logic [6:0] SPI_DEFAULT_ADDR = 7'h40;
   localparam logic [6:0] I2C_DEFAULT_BASE = 7'h40;
   localparam int ENABLE_BIT = 0;
   localparam int POINTER_AUTO_INCREMENT_BIT = 7;
   localparam int MAP_BITS = 7;
   localparam logic [2:0] BIT_LAST = 3'h7;
   typedef enum logic [1:0] {
      DMSC_MODE_NONE,
      DMSC_MODE_I2C,
      DMSC_MODE_SPI
   } dmsc_mode_t;
endpackage

// File: dmsc_link_if.sv
/*
 dmsc_link_if: wires between the controller and the device, one modport each.
 assumes: the interface resolves the open-drain data line from the enables.
*/
`timescale 1ns/100ps
interface dmsc_link_if;
   logic scl;
   logic sda_ctl_oe;
   logic sda_dev_oe;
   logic sda;
   logic cs_n;
   logic mosi;
   logic reset_n;
   logic chain_enable_out;
   assign sda = !(sda_ctl_oe || sda_dev_oe);
   modport device (
      input scl,
      input sda,
      output sda_dev_oe,
      input cs_n,
      input mosi,
      input reset_n,
      output chain_enable_out
   );
   modport ctrl (
      output scl,
      input sda,
      output sda_ctl_oe,
      output cs_n,
      output mosi,
      output reset_n,
      input chain_enable_out
   );
endinterface

// File: dmsc_ctrl.sv
/*
 dmsc_ctrl: controller end, an APB slave that runs I2C or SPI transfers.
 assumes: APB master on the same clock; one device chain on the link.
 registers: 0x00 ctrl (wo: bit0 go, bit1 spi, bit2 read, bit3 stop_after_ptr,
 bit4 chain reset_n), 0x04 tx {addr7,ptr8,data8}, 0x08 status (bit0 busy,
 bit1 nack seen, bit2 chain_enable), 0x0C rx data.
*/
`timescale 1ns/100ps
module dmsc_ctrl (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   dmsc_link_if.ctrl link
);
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_TX = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_RX = 8'h0C;
   typedef enum logic [2:0] {C_IDLE, C_START, C_BIT, C_ACK, C_STOP} cst_t;
   typedef struct packed {
      cst_t st;
      logic [15:0] div;
      logic phase;
      logic [2:0] bitn;
      logic [1:0] byten;
      logic [22:0] tx;
      logic spi;
      logic rd;
      logic stop_ptr;
      logic rst_out;
      logic nack;
      logic [7:0] rx;
      logic [7:0] sh;
      logic scl;
      logic sda_oe;
      logic cs_n;
      logic mosi;
      logic s1;
      logic s2;
      logic e1;
      logic e2;
   } dmsc_cst_t;
   dmsc_cst_t r, next_r;
   logic wr;
   logic tick;
   logic [1:0] nbytes;
   assign wr = psel && penable && pwrite;
   assign pready = 1'b1;
   assign link.scl = r.scl;
   assign link.sda_ctl_oe = r.sda_oe;
   assign link.cs_n = r.cs_n;
   assign link.mosi = r.mosi;
   assign link.reset_n = r.rst_out;
   always_comb begin
      prdata = 32'h0;
      pslverr = 1'b0;
      unique case (paddr)
         A_STAT: prdata = {29'h0, r.e2, r.nack, r.st != C_IDLE};
         A_RX: prdata = {24'h0, r.rx};
         A_TX: prdata = {9'h0, r.tx};
         A_CTRL: prdata = 32'h0;
         default: pslverr = psel && penable;
      endcase
   end
   assign tick = (r.div == 16'(dmsc_pkg::HALF_BIT_CYCLES - 1));
   assign nbytes = r.rd ? 2'h0 : (r.stop_ptr ? 2'h1 : 2'h2);
   always_comb begin
      next_r = r;
      next_r.s1 = link.sda;
      next_r.s2 = r.s1;
      next_r.e1 = link.chain_enable_out;
      next_r.e2 = r.e1;
      next_r.div = (r.st == C_IDLE || tick) ? 16'h0 : r.div + 16'h1;
      if (wr && paddr == A_TX && r.st == C_IDLE) begin
         next_r.tx = pwdata[22:0];
      end
      if (wr && paddr == A_CTRL) begin
         next_r.rst_out = pwdata[4];
         if (pwdata[0] && r.st == C_IDLE) begin
            next_r.spi = pwdata[1];
            next_r.rd = pwdata[2];
            next_r.stop_ptr = pwdata[3];
            next_r.nack = 1'b0;
            next_r.byten = 2'h0;
            next_r.bitn = 3'h0;
            next_r.sh = {r.tx[22:16], pwdata[2]};
            next_r.st = C_START;
         end
      end
      if (tick) begin
         next_r.phase = !r.phase;
         unique case (r.st)
            C_IDLE: ;
            C_START: begin
               if (r.spi) next_r.cs_n = 1'b0;
               else next_r.sda_oe = 1'b1;
               next_r.phase = 1'b0;
               next_r.st = C_BIT;
            end
            C_BIT: begin
               if (!r.phase) begin
                  next_r.scl = 1'b0;
                  next_r.sda_oe = !r.rd || r.byten == 2'h0 ? !r.sh[7] : 1'b0;
                  next_r.mosi = r.sh[7];
               end else begin
                  next_r.scl = 1'b1;
                  next_r.rx = {r.rx[6:0], r.s2};
                  next_r.sh = {r.sh[6:0], 1'b0};
                  next_r.bitn = r.bitn + 3'h1;
                  if (r.bitn == dmsc_pkg::BIT_LAST) next_r.st = r.spi ? C_BIT : C_ACK;
                  if (r.bitn == dmsc_pkg::BIT_LAST && r.spi) begin
                     next_r.byten = r.byten + 2'h1;
                     next_r.sh = r.byten == 2'h0 ? r.tx[15:8] : r.tx[7:0];
                     if (r.byten == nbytes) next_r.st = C_STOP;
                  end
               end
            end
            C_ACK: begin
               if (!r.phase) begin
                  next_r.scl = 1'b0;
                  // the single read byte is the last one, so it is answered with a nack
                  next_r.sda_oe = 1'b0;
               end else begin
                  next_r.scl = 1'b1;
                  if (!(r.rd && r.byten != 2'h0) && r.s2) next_r.nack = 1'b1;
                  next_r.byten = r.byten + 2'h1;
                  next_r.sh = r.byten == 2'h0 ? r.tx[15:8] : r.tx[7:0];
                  if (r.rd) next_r.st = r.byten == 2'h0 ? C_BIT : C_STOP;
                  else next_r.st = (r.byten == nbytes || r.s2) ? C_STOP : C_BIT;
               end
            end
            C_STOP: begin
               if (!r.phase) begin
                  next_r.scl = r.spi;
                  next_r.sda_oe = !r.spi;
               end else if (!r.scl) begin
                  // raise the clock first so data rises while it is high
                  next_r.scl = 1'b1;
                  next_r.phase = 1'b1;
               end else begin
                  next_r.sda_oe = 1'b0;
                  next_r.cs_n = 1'b1;
                  next_r.st = C_IDLE;
               end
            end
            default: next_r.st = C_IDLE;
         endcase
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.scl <= 1'b1;
         r.cs_n <= 1'b1;
         r.s1 <= 1'b1;
         r.s2 <= 1'b1;
      end else begin
         r <= next_r;
      end
   end
endmodule // dmsc_ctrl

// File: dmsc_link_properties.sv
/*
 dmsc_link_properties: timing checks on the link between controller and device.
 assumes: instantiated in tb_top beside the link interface; one clock domain.
*/
`timescale 1ns/100ps
module dmsc_link_properties (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_ctl_oe,
   input wire logic sda_dev_oe,
   input wire logic cs_n,
   input wire logic reset_n,
   input wire logic chain_enable_out
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   chain_low_a: assert property (!reset_n ##1 !reset_n |-> !chain_enable_out)
      else $error("chain enable high while chain held in reset");
   chain_rise_a: assert property ($rose(chain_enable_out) |-> reset_n && $past(reset_n, 8))
      else $error("chain enable rose without reset released");
   dev_edge_a: assert property ($changed(sda_dev_oe) |-> !scl && !$past(scl, 2))
      else $error("device data changed while clock high");
   ack_hold_a: assert property ($rose(sda_dev_oe) |-> sda_dev_oe[*8] ##[1:900] !sda_dev_oe)
      else $error("device drive too short or never released");
   ack_free_a: assert property ($rose(sda_dev_oe) |-> !sda_ctl_oe && !sda)
      else $error("device drove while controller drives");
   spi_quiet_a: assert property (!cs_n |-> !sda_dev_oe)
      else $error("device drove data line during select frame");
   reset_quiet_a: assert property (!reset_n ##1 !reset_n |-> !sda_dev_oe)
      else $error("device drove data line in reset");
   scl_half_a: assert property ($rose(scl) |-> scl[*8])
      else $error("clock high phase too short");

   cover property ($rose(chain_enable_out));
   cover property ($rose(sda_dev_oe));
   cover property ($fell(cs_n));
endmodule // dmsc_link_properties

// File: tb_top.sv
/*
 tb_top: controller and device joined by the link; APB drives the controller.
 assumes: 20 MHz clock; the bench models the other registers as addr ^ 5A.
*/
`timescale 1ns/100ps
module tb_top;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic address_select_pin = 1'b1;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata = 8'h00;
   logic reg_write;
   logic [7:0] last_addr;
   logic [7:0] last_data;
   logic [31:0] q;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int writes_seen = 0;
   int w0;

   dmsc_link_if link ();
   dmsc_ctrl i_dmsc_ctrl (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   dmsc_device i_dmsc_device (.clock(clock), .rst_n(rst_n),
      .address_select_pin(address_select_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_rdata(reg_rdata), .link(link));
   dmsc_link_properties i_dmsc_link_properties (.clock(clock), .rst_n(rst_n), .scl(link.scl),
      .sda(link.sda), .sda_ctl_oe(link.sda_ctl_oe), .sda_dev_oe(link.sda_dev_oe),
      .cs_n(link.cs_n), .reset_n(link.reset_n), .chain_enable_out(link.chain_enable_out));

   always #25 clock = ~clock;

   always @(posedge clock) begin
      reg_rdata <= reg_addr ^ 8'h5A;
      if (reg_write === 1'b1) begin
         writes_seen++;
         last_addr <= reg_addr;
         last_data <= reg_wdata;
      end
      cycles++;
      if (cycles == 90000) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      q[31] = (pslverr === 1'b1) ? 1'b1 : q[31];
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // one transfer; bit4 keeps the chain out of reset, bit0 starts it
   task automatic xfer(input logic [3:0] ctl, input logic [6:0] a, input logic [7:0] p,
                       input logic [7:0] d);
      w0 = writes_seen;
      apb(1'b1, 8'h04, {9'h000, a, p, d});
      apb(1'b1, 8'h00, {27'h0, 1'b1, ctl[3:1], 1'b1});
      do apb(1'b0, 8'h08, 32'h0); while (q[0] !== 1'b0);
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] p, input logic [7:0] exp);
      xfer(4'h8, a, p, 8'h00);
      xfer(4'h4, a, 8'h00, 8'h00);
      apb(1'b0, 8'h0C, 32'h0);
      check("read data", {24'h0, q[7:0]}, {24'h0, exp});
   endtask

   task automatic t_reset();
      check("chain in reset", link.chain_enable_out, 1'b0);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped error", q[31], 1'b1);
      apb(1'b1, 8'h00, 32'h10);
      repeat (20) @(posedge clock);
      check("chain before enable", link.chain_enable_out, 1'b0);
   endtask

   task automatic t_i2c();
      xfer(4'h0, 7'h41, 8'h85, 8'h3C);
      check("ack", q[1], 1'b0);
      check("write count", writes_seen - w0, 1);
      check("write reg", last_addr, 8'h05);
      check("write data", last_data, 8'h3C);
      xfer(4'h4, 7'h41, 8'h00, 8'h00);
      apb(1'b0, 8'h0C, 32'h0);
      check("auto increment", {24'h0, q[7:0]}, 32'h0000005C);
      xfer(4'h0, 7'h23, 8'h05, 8'h11);
      check("foreign nack", q[1], 1'b1);
      check("foreign write", writes_seen - w0, 0);
      rd(7'h41, 8'h07, 8'h5D);
      rd(7'h41, 8'h1B, 8'h82);
   endtask

   task automatic t_group();
      xfer(4'h0, 7'h41, 8'h1A, {7'h30, 1'b1});
      xfer(4'h0, 7'h41, 8'h19, {7'h31, 1'b0});
      xfer(4'h0, 7'h30, 8'h02, 8'h77);
      check("group write", {q[1], last_addr, last_data}, {1'b0, 16'h0277});
      xfer(4'h4, 7'h30, 8'h00, 8'h00);
      check("group read nack", q[1], 1'b1);
      xfer(4'h0, 7'h31, 8'h02, 8'h66);
      check("disabled group nack", q[1], 1'b1);
      check("disabled group write", writes_seen - w0, 0);
   endtask

   task automatic t_chain();
      xfer(4'h0, 7'h41, 8'h1B, {7'h22, 1'b1});
      repeat (10) @(posedge clock);
      check("chain enabled", link.chain_enable_out, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      check("chain status", q[2], 1'b1);
      rd(7'h22, 8'h1B, 8'h45);
      apb(1'b1, 8'h00, 32'h0);
      repeat (10) @(posedge clock);
      check("chain reset", link.chain_enable_out, 1'b0);
      address_select_pin <= 1'b0;
      apb(1'b1, 8'h00, 32'h10);
      repeat (10) @(posedge clock);
      rd(7'h40, 8'h1B, 8'h80);
   endtask

   task automatic t_spi();
      apb(1'b1, 8'h00, 32'h10);
      repeat (10) @(posedge clock);
      xfer(4'h2, 7'h40, 8'h03, 8'hA5);
      check("spi write", {8'(writes_seen - w0), last_addr, last_data}, {8'h01, 16'h03A5});
      xfer(4'h6, 7'h40, 8'h04, 8'h99);
      check("spi read ignored", writes_seen - w0, 0);
      xfer(4'h2, 7'h40, 8'h06, 8'h5B);
      check("spi reselect", {last_addr, last_data}, 16'h065B);
   endtask

   initial begin
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_i2c();
      t_group();
      t_chain();
      t_spi();
      wrap_up();
   end
endmodule // tb_top
